// file: hw/rss_code_filter.sv
`include "rss_params.svh"
`default_nettype none
module rss_code_filter
  import rss_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = `RSS_SETTLE_CYC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Raw code from the pins.
  input wire rss_pkg::rss_code_t raw_code,
  // Settled code, stable level and update pulse.
  output rss_pkg::rss_code_t code,
  output logic stable,
  output logic upd
);
  rss_filt_s q; // Registered state.
  rss_filt_s d; // Next state.

  // Any movement of the bus restarts the settle count, so skewed bits
  // passing through intermediate values are never latched.
  always_comb
  begin
    d = q;
    d.upd = 1'b0;
    d.last = raw_code;
    if (raw_code != q.last)
    begin
      // Change seen: hide it until it has stood still long enough.
      d.cnt = '0;
      d.stable = 1'b0;
    end
    else if (q.cnt < SETTLE_CYC[`RSS_SET_W-1:0] - 8'h01)
    begin
      // Still settling.
      d.cnt = q.cnt + 8'h01;
    end
    else if (!q.stable)
    begin
      // Settled: take the new code and tell the sequencer once.
      d.stable = 1'b1;
      d.code = q.last;
      d.upd = 1'b1;
    end
  end

  // State register.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign code = q.code;
  assign stable = q.stable;
  assign upd = q.upd;
endmodule : rss_code_filter
`default_nettype wire

// file: hw/rss_sequencer.sv
// The Avalon-MM slave port and the address map are this design's own decisions.
`include "rss_params.svh"
`default_nettype none
module rss_sequencer
  import rss_pkg::*;
#(
  parameter int unsigned TD1_CYC = `RSS_TD1_CYC,
  parameter int unsigned BOOT_RAMP_CYC = `RSS_BOOT_RAMP_CYC,
  parameter int unsigned HOLD_CYC = `RSS_HOLD_CYC,
  parameter int unsigned TGT_RAMP_CYC = `RSS_TGT_RAMP_CYC,
  parameter int unsigned MS_CYC = `RSS_MS_CYC,
  parameter int unsigned SETTLE_CYC = `RSS_SETTLE_CYC
) (
  // Clock and reset.
  input wire logic CLK,
  input wire logic NRST,
  // Avalon-MM register slave.
  input wire logic [`RSS_ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Supply monitors and board control.
  input wire logic UNDERVOLTAGE_LOCKOUT_VCC_OK,
  input wire logic UNDERVOLTAGE_LOCKOUT_CONV_OK,
  input wire logic CONFIG_DONE,
  input wire logic REGULATOR_ENABLE_IN,
  input wire logic CODE_TABLE_SELECT,
  // Processor voltage code bus, eight controller inputs.
  input wire rss_pkg::rss_code_t VOLTAGE_IDENT_CODE,
  // Converter control outputs.
  output rss_pkg::rss_code_t REF_CODE,
  output logic OUTPUT_HIZ,
  output logic LOADLINE_EN,
  output logic SOFT_START_ACTIVE,
  output logic TABLE_SEL_LATCHED,
  output logic LATCHED_OFF,
  output logic REGULATOR_POWER_GOOD_OUT
);
  rss_seq_s q; // Registered state.
  rss_seq_s d; // Next state.

  rss_code_t code_filt; // Settled code.
  logic code_stable; // Settled code is valid.
  logic code_upd; // One-cycle pulse on a newly settled code.
  logic supplies_ok; // Both supply rails are good.
  logic bus_req; // A bus request is pending.
  logic bus_done; // The master samples the answer this edge.

  // Soft-start ramp length. A setting of zero keeps the built-in
  // default; one to five selects whole milliseconds, larger values
  // clamp to five. The target ramp runs at half the boot ramp time.
  function automatic rss_cnt_t ramp_len(input logic [`RSS_CTRL_SS_W-1:0] ms,
                                        input logic second);
    int unsigned n;
    int unsigned c;
    n = (ms > `RSS_SS_MAX_MS) ? `RSS_SS_MAX_MS : int'(ms);
    if (n == 0)
    begin
      c = second ? TGT_RAMP_CYC : BOOT_RAMP_CYC;
    end
    else
    begin
      c = n * MS_CYC;
      if (second)
      begin
        c = c / 2;
      end
    end
    if (c == 0)
    begin
      c = 1;
    end
    return rss_cnt_t'(c - 1);
  endfunction : ramp_len

  // True for the only code that means off. Inputs from an empty
  // socket are pulled to zero, which latches the rail off once the boot hold ends.
  function automatic logic is_off(input rss_code_t c);
    return c == `RSS_OFF_CODE;
  endfunction : is_off

  // The settle filter on the code bus. The board wires processor bits
  // 5..0 to inputs 6..1 and grounds 7 and 0, so the eight-bit code is
  // taken as it stands with no shifting here.
  rss_code_filter #(
    .SETTLE_CYC(SETTLE_CYC)
  ) u_filter (
    .clk(CLK),
    .nrst(NRST),
    .raw_code(VOLTAGE_IDENT_CODE),
    .code(code_filt),
    .stable(code_stable),
    .upd(code_upd)
  );

  // Enable is used as a level every cycle outside the latched state; no edge is looked for.
  assign supplies_ok = UNDERVOLTAGE_LOCKOUT_VCC_OK & UNDERVOLTAGE_LOCKOUT_CONV_OK;
  assign bus_req = AVS_READ | AVS_WRITE;
  assign bus_done = bus_req & ~q.waitreq;

  // Next-state logic: register slave first, then the sequence.
  always_comb
  begin
    d = q;
    // The slave answers one cycle after a request arrives: wait is
    // dropped for exactly one cycle, then raised again.
    d.waitreq = 1'b1;
    if (bus_req && q.waitreq)
    begin
      // Answer next cycle with the read data ready.
      d.waitreq = 1'b0;
      case (AVS_ADDRESS)
        `RSS_REG_CTRL:
        begin
          d.rdata = 32'h0;
          d.rdata[`RSS_CTRL_SS_LSB +: `RSS_CTRL_SS_W] = q.ss_ms;
        end
        `RSS_REG_STATUS:
        begin
          d.rdata = 32'h0;
          d.rdata[6:0] = q.state;
          d.rdata[`RSS_STAT_PG_BIT] = q.pg;
          d.rdata[`RSS_STAT_LATCH_BIT] = (q.state == ST_LATCHED);
          d.rdata[`RSS_STAT_TABLE_BIT] = q.table_sel;
          d.rdata[`RSS_STAT_HIZ_BIT] = q.hiz;
          d.rdata[`RSS_STAT_LL_BIT] = q.ll_en;
          d.rdata[`RSS_STAT_SS_BIT] = q.ss_active;
        end
        `RSS_REG_CODE:
        begin
          d.rdata = 32'h0;
          d.rdata[7:0] = q.target;
          d.rdata[`RSS_CODE_RAW_LSB +: 8] = code_filt;
        end
        default:
        begin
          // Unmapped words read as zero.
          d.rdata = 32'h0;
        end
      endcase
    end
    // A write lands on the edge where the master sees wait low.
    if (bus_done && AVS_WRITE && AVS_ADDRESS == `RSS_REG_CTRL && AVS_BYTEENABLE[0])
    begin
      d.ss_ms = AVS_WRITEDATA[`RSS_CTRL_SS_LSB +: `RSS_CTRL_SS_W];
    end

    // Sequence. Only one start-up order exists; the table select never
    // changes the order of steps.
    if (q.state == ST_LATCHED)
    begin
      // Off code seen: stay off until reset cycles the power.
      d.pg = 1'b0;
      d.hiz = 1'b1;
    end
    else if (!supplies_ok || !CONFIG_DONE || !REGULATOR_ENABLE_IN)
    begin
      // Any loss of supply or enable drops everything at once and
      // sends the sequence back to its beginning.
      d.state = ST_OFF;
      d.pg = 1'b0;
      d.hiz = 1'b1;
      d.ll_en = 1'b0;
      d.ss_active = 1'b0;
      d.ref_code = `RSS_BOOT_CODE;
      d.cnt = '0;
    end
    else
    begin
      case (q.state)
        ST_OFF:
        begin
          // All start conditions met: begin the start delay.
          d.state = ST_DELAY;
          d.cnt = rss_cnt_t'(TD1_CYC - 1);
          d.table_sel = CODE_TABLE_SELECT;
        end
        ST_DELAY:
        begin
          // The static table strap is followed for the whole delay.
          d.table_sel = CODE_TABLE_SELECT;
          if (q.cnt == '0)
          begin
            // Leave high impedance and ramp to the boot level.
            d.state = ST_BOOT_RAMP;
            d.cnt = ramp_len(q.ss_ms, 1'b0);
            d.hiz = 1'b0;
            d.ss_active = 1'b1;
            d.ref_code = `RSS_BOOT_CODE;
            d.ll_en = 1'b0;
          end
          else
          begin
            d.cnt = q.cnt - 1'b1;
          end
        end
        ST_BOOT_RAMP:
        begin
          if (q.cnt == '0)
          begin
            d.state = ST_BOOT_HOLD;
            d.cnt = rss_cnt_t'(HOLD_CYC - 1);
            d.ss_active = 1'b0;
          end
          else
          begin
            d.cnt = q.cnt - 1'b1;
          end
        end
        ST_BOOT_HOLD:
        begin
          // The code bus is ignored until the hold has run out. If the
          // code is still settling then, the hold is stretched.
          if (q.cnt != '0)
          begin
            d.cnt = q.cnt - 1'b1;
          end
          else if (code_stable)
          begin
            if (is_off(code_filt))
            begin
              d.state = ST_LATCHED;
              d.hiz = 1'b1;
            end
            else
            begin
              d.state = ST_TGT_RAMP;
              d.target = code_filt;
              d.cnt = ramp_len(q.ss_ms, 1'b1);
              d.ss_active = 1'b1;
            end
          end
        end
        ST_TGT_RAMP:
        begin
          if (q.cnt == '0)
          begin
            // Target reached: the code now rules and ready rises.
            d.state = ST_RUN;
            d.ref_code = q.target;
            d.ll_en = 1'b1;
            d.ss_active = 1'b0;
            d.pg = 1'b1;
          end
          else
          begin
            d.cnt = q.cnt - 1'b1;
          end
        end
        ST_RUN:
        begin
          // Settled code changes are followed while running.
          if (code_upd)
          begin
            if (is_off(code_filt))
            begin
              // Turned off on the next edge, far within the limit.
              d.state = ST_LATCHED;
              d.pg = 1'b0;
              d.hiz = 1'b1;
            end
            else
            begin
              d.target = code_filt;
              d.ref_code = code_filt;
            end
          end
        end
        default:
        begin
          // Illegal encoding: fall back to the safe off state.
          d.state = ST_OFF;
          d.pg = 1'b0;
          d.hiz = 1'b1;
        end
      endcase
    end
  end

  // State register; reset leaves the rail off and impedance high.
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      q <= '{state: ST_OFF, cnt: '0, ref_code: `RSS_BOOT_CODE, target: 8'h00,
             ss_ms: 3'h0, table_sel: 1'b0, pg: 1'b0, hiz: 1'b1, ll_en: 1'b0,
             ss_active: 1'b0, waitreq: 1'b1, rdata: 32'h0};
    end
    else
    begin
      q <= d;
    end
  end

  // Outputs straight from the state register.
  assign AVS_READDATA = q.rdata;
  assign AVS_WAITREQUEST = q.waitreq;
  assign REF_CODE = q.ref_code;
  assign OUTPUT_HIZ = q.hiz;
  assign LOADLINE_EN = q.ll_en;
  assign SOFT_START_ACTIVE = q.ss_active;
  assign TABLE_SEL_LATCHED = q.table_sel;
  assign LATCHED_OFF = (q.state == ST_LATCHED);
  assign REGULATOR_POWER_GOOD_OUT = q.pg;
endmodule : rss_sequencer
`default_nettype wire

// file: inc/rss_params.svh
`ifndef RSS_PARAMS_SVH
`define RSS_PARAMS_SVH
// Overview of operation
// - Only the newer start-up order exists.
// - Start delay needs supplies, configuration, enable.
// - After delay, ramp to boot level.
// - Hold boot level, then read code.
// - Boot level acts as 1.1 V, no load-line.
// - Enable is a level, never an edge.
// - Enable loss abandons sequence; restart later.
// - Enable low: ready low, output high impedance.
// - Stay off until both supplies valid.
// - Supply loss shuts down, then full restart.
// - Default soft-start ramp is 500 us.
// - Soft-start setting lengthens ramp to 1-5 ms.
// - Soft-start sets both ramps; second half length.
// - Eight-bit code sets the regulated level.
// - Processor bits 5..0 arrive on bits 6..1.
// - Off code turns output off, latched.
// - Only the all-zero code means off.
// - Code changes settle 400 ns before use.
// - Table select is sampled during start delay.

// Clock rate and interval lengths in their own units.
`define RSS_CLK_MHZ 100
`define RSS_TD1_US 2000
`define RSS_BOOT_RAMP_US 500
`define RSS_HOLD_US 100
`define RSS_TGT_RAMP_US 250
`define RSS_SETTLE_NS 400
`define RSS_SS_MAX_MS 5
// Derived cycle counts.
`define RSS_TD1_CYC (`RSS_TD1_US * `RSS_CLK_MHZ)
`define RSS_BOOT_RAMP_CYC (`RSS_BOOT_RAMP_US * `RSS_CLK_MHZ)
`define RSS_HOLD_CYC (`RSS_HOLD_US * `RSS_CLK_MHZ)
`define RSS_TGT_RAMP_CYC (`RSS_TGT_RAMP_US * `RSS_CLK_MHZ)
`define RSS_SETTLE_CYC ((`RSS_SETTLE_NS * `RSS_CLK_MHZ + 999) / 1000)
`define RSS_MS_CYC (1000 * `RSS_CLK_MHZ)
// Widths and code values.
`define RSS_CNT_W 20
`define RSS_SET_W 8
`define RSS_BOOT_CODE 8'h4a
`define RSS_OFF_CODE 8'h00
// Register map and fields.
`define RSS_ADDR_W 4
`define RSS_REG_CTRL 4'h0
`define RSS_REG_STATUS 4'h4
`define RSS_REG_CODE 4'h8
`define RSS_CTRL_SS_LSB 0
`define RSS_CTRL_SS_W 3
`define RSS_STAT_PG_BIT 8
`define RSS_STAT_LATCH_BIT 9
`define RSS_STAT_TABLE_BIT 10
`define RSS_STAT_HIZ_BIT 11
`define RSS_STAT_LL_BIT 12
`define RSS_STAT_SS_BIT 13
`define RSS_CODE_RAW_LSB 8
`endif

// file: inc/rss_pkg.sv
`include "rss_params.svh"
`default_nettype none
package rss_pkg;
  // Sequencer states, one-hot.
  typedef enum logic [6:0] {
    ST_OFF = 7'h01,
    ST_DELAY = 7'h02,
    ST_BOOT_RAMP = 7'h04,
    ST_BOOT_HOLD = 7'h08,
    ST_TGT_RAMP = 7'h10,
    ST_RUN = 7'h20,
    ST_LATCHED = 7'h40
  } rss_state_e;

  typedef logic [`RSS_CNT_W-1:0] rss_cnt_t;
  typedef logic [7:0] rss_code_t;

  // Whole state of the sequencer.
  typedef struct packed {
    rss_state_e state;
    rss_cnt_t cnt;
    rss_code_t ref_code;
    rss_code_t target;
    logic [`RSS_CTRL_SS_W-1:0] ss_ms;
    logic table_sel;
    logic pg;
    logic hiz;
    logic ll_en;
    logic ss_active;
    logic waitreq;
    logic [31:0] rdata;
  } rss_seq_s;

  // Whole state of the code settling filter.
  typedef struct packed {
    rss_code_t last;
    logic [`RSS_SET_W-1:0] cnt;
    rss_code_t code;
    logic stable;
    logic upd;
  } rss_filt_s;
endpackage : rss_pkg
`default_nettype wire

// file: verif/regulator_startup_sequencer_bench.sv
`default_nettype none
module regulator_startup_sequencer_bench
  import rss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int UP = 61; // Start to ready: 1 + 20 delay + 20 ramp + 10 hold + 10 ramp.
  logic clk = 1'b0, nrst = 1'b0, rd_en = 1'b0, wr_en = 1'b0, tsel = 1'b1, wait_n;
  logic [3:0] ctl = 4'h0; // Vcc ok, conv ok, config done, enable.
  logic [3:0] addr = 4'h0;
  logic [3:0] be = 4'hf; // Byte enables; a cleared bit 0 must block a control write.
  logic [31:0] wdata = 32'h0, rdata, q;
  logic [5:0] cpu = 6'h13;
  rss_code_t pins, ref_code;
  logic hiz, ll, ss, tbl, latched, pg;
  logic [2:0] mon;
  int fails = 0, comparisons = 0, n;
  assign mon = {latched, ss, pg};
  rss_sequencer #(.TD1_CYC(20), .BOOT_RAMP_CYC(16), .HOLD_CYC(10), .TGT_RAMP_CYC(8),
    .MS_CYC(10), .SETTLE_CYC(40)) dut (.CLK(clk), .NRST(nrst), .AVS_ADDRESS(addr),
    .AVS_READ(rd_en), .AVS_WRITE(wr_en), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be),
    .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_n), .UNDERVOLTAGE_LOCKOUT_VCC_OK(ctl[3]),
    .UNDERVOLTAGE_LOCKOUT_CONV_OK(ctl[2]), .CONFIG_DONE(ctl[1]), .REGULATOR_ENABLE_IN(ctl[0]),
    .CODE_TABLE_SELECT(tsel), .VOLTAGE_IDENT_CODE(pins), .REF_CODE(ref_code), .OUTPUT_HIZ(hiz),
    .LOADLINE_EN(ll), .SOFT_START_ACTIVE(ss), .TABLE_SEL_LATCHED(tbl), .LATCHED_OFF(latched),
    .REGULATOR_POWER_GOOD_OUT(pg));
  rss_cpu_model cpu_m (.clk(clk), .nrst(nrst), .cpu_code(cpu), .code_pins(pins));
  // Verdict; reached from the test sequence or the watchdog.
  task close_out;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out
  // One comparison with four-state equality.
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: %s seen %h", $time, what, seen);
    end
  endtask : chk
  // Bus cycle held until waitrequest is seen low at a rising edge.
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] r);
    int k;
    @(posedge clk);
    addr <= a;
    wdata <= wd;
    wr_en <= wr;
    rd_en <= !wr;
    k = 0;
    do
    begin
      @(negedge clk);
      k++;
    end
    while (wait_n !== 1'b0 && k < 100);
    if (k >= 100)
    begin
      fails++;
      $display("unexpected at %0t: bus answer missing", $time);
    end
    // Wait and read data stand until the coming rising edge samples them.
    r = rdata;
    @(posedge clk);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
  endtask : bus
  // Bounded wait for a monitored output to go high.
  task waitm(input int b, output int k);
    k = 0;
    while (mon[b] !== 1'b1 && k < 1000)
    begin
      @(negedge clk);
      k++;
    end
    if (k >= 1000)
    begin
      fails++;
      $display("unexpected at %0t: output never rose", $time);
    end
  endtask : waitm
  initial
  begin
    forever #5 clk = ~clk;
  end
  // The whole run needs about 750 cycles.
  initial
  begin
    repeat (5000) @(posedge clk);
    fails++;
    $display("unexpected at %0t: watchdog", $time);
    close_out();
  end
  initial
  begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    bus(1'b0, 4'h4, 32'h0, q);
    chk(q, 32'h801, "idle status");
    bus(1'b1, 4'h0, 32'h2, q);
    bus(1'b0, 4'h0, 32'h0, q);
    chk(q, 32'h2, "soft start");
    be <= 4'he;
    bus(1'b1, 4'h0, 32'h5, q);
    be <= 4'hf;
    bus(1'b0, 4'h0, 32'h0, q);
    chk(q, 32'h2, "masked write");
    bus(1'b0, 4'hc, 32'h0, q);
    chk(q, 32'h0, "unmapped");
    $display("test registers done");
    @(posedge clk);
    ctl <= 4'hf;
    waitm(0, n);
    chk(32'(n >= UP - 2 && n <= UP + 2), 32'h1, "start time");
    chk(ref_code, 8'h26, "target");
    chk(tbl, 1'b1, "table high");
    bus(1'b0, 4'h4, 32'h0, q);
    chk(q, 32'h1520, "run status");
    bus(1'b0, 4'h8, 32'h0, q);
    chk(q, 32'h2626, "code reg");
    $display("test start done");
    cpu <= 6'h20;
    repeat (30) @(negedge clk);
    chk(ref_code, 8'h26, "early code");
    repeat (60) @(negedge clk);
    chk(ref_code, 8'h40, "new code");
    $display("test dynamic done");
    // The strap is only looked at during a start delay, so the restarts
    // below must pick up the low level.
    tsel <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      ctl[i] <= 1'b0;
      repeat (2) @(negedge clk);
      chk({pg, hiz}, 2'b01, "drop in run");
      @(posedge clk);
      ctl[i] <= 1'b1;
      waitm(1, n);
      @(posedge clk);
      ctl[i] <= 1'b0;
      repeat (2) @(negedge clk);
      chk({pg, hiz, ss}, 3'b010, "drop in ramp");
      @(posedge clk);
      ctl[i] <= 1'b1;
      waitm(0, n);
      chk(32'(n >= UP - 2 && n <= UP + 2), 32'h1, "restart");
    end
    chk(tbl, 1'b0, "table low");
    $display("test abort done");
    cpu <= 6'h00;
    waitm(2, n);
    chk(latched, 1'b1, "off code");
    @(posedge clk);
    ctl[0] <= 1'b0;
    @(posedge clk);
    ctl[0] <= 1'b1;
    repeat (100) @(negedge clk);
    chk({latched, pg}, 2'b10, "stays off");
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk(latched, 1'b0, "power cycle");
    $display("test off done");
    close_out();
  end
endmodule : regulator_startup_sequencer_bench
bind rss_sequencer rss_seq_chk #(.TD1_CYC(TD1_CYC), .SETTLE_CYC(SETTLE_CYC)) chk_i (
  .CLK(CLK), .NRST(NRST), .UNDERVOLTAGE_LOCKOUT_VCC_OK(UNDERVOLTAGE_LOCKOUT_VCC_OK),
  .UNDERVOLTAGE_LOCKOUT_CONV_OK(UNDERVOLTAGE_LOCKOUT_CONV_OK), .CONFIG_DONE(CONFIG_DONE),
  .REGULATOR_ENABLE_IN(REGULATOR_ENABLE_IN), .VOLTAGE_IDENT_CODE(VOLTAGE_IDENT_CODE),
  .REF_CODE(REF_CODE), .OUTPUT_HIZ(OUTPUT_HIZ), .LOADLINE_EN(LOADLINE_EN),
  .SOFT_START_ACTIVE(SOFT_START_ACTIVE), .LATCHED_OFF(LATCHED_OFF),
  .REGULATOR_POWER_GOOD_OUT(REGULATOR_POWER_GOOD_OUT));
`default_nettype wire

// file: verif/rss_cpu_model.sv
`default_nettype none
module rss_cpu_model
  import rss_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Code the processor means to present.
  input wire logic [5:0] cpu_code,
  // Controller code inputs.
  output rss_pkg::rss_code_t code_pins
);
  logic [5:0] tgt_q; // Code being sent.
  logic [3:0] skew_q; // Cycles of line skew left.
  // A new code skews for ten cycles; the lines move every cycle meanwhile, so a
  // controller that latches early sees garbage.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tgt_q <= 6'h00;
      skew_q <= 4'h0;
    end
    else if (cpu_code != tgt_q)
    begin
      tgt_q <= cpu_code;
      skew_q <= 4'ha;
    end
    else if (skew_q != 4'h0)
    begin
      skew_q <= skew_q - 4'h1;
    end
  end
  // Bits sit one place up; the two spare inputs are grounded.
  assign code_pins = {1'b0, (skew_q != 4'h0) ? tgt_q ^ {2'h3, skew_q} : tgt_q, 1'b0};
endmodule : rss_cpu_model
`default_nettype wire

// file: verif/rss_seq_chk_sva.sv
`default_nettype none
module rss_seq_chk
  import rss_pkg::*;
#(
  parameter int unsigned TD1_CYC = 20,
  parameter int unsigned SETTLE_CYC = 40
) (
  // Clock and reset.
  input wire logic CLK,
  input wire logic NRST,
  // Supplies, enable and code bus.
  input wire logic UNDERVOLTAGE_LOCKOUT_VCC_OK,
  input wire logic UNDERVOLTAGE_LOCKOUT_CONV_OK,
  input wire logic CONFIG_DONE,
  input wire logic REGULATOR_ENABLE_IN,
  input wire rss_pkg::rss_code_t VOLTAGE_IDENT_CODE,
  // Converter outputs.
  input wire rss_pkg::rss_code_t REF_CODE,
  input wire logic OUTPUT_HIZ,
  input wire logic LOADLINE_EN,
  input wire logic SOFT_START_ACTIVE,
  input wire logic LATCHED_OFF,
  input wire logic REGULATOR_POWER_GOOD_OUT
);
  logic all_ok; // Every start condition met.
  int unsigned ok_q; // Cycles all_ok has held; no wrap within a bench run.
  int unsigned stab_q; // Cycles the code pins have not moved.
  rss_code_t last_q; // Code pins one cycle ago.
  assign all_ok = UNDERVOLTAGE_LOCKOUT_VCC_OK && UNDERVOLTAGE_LOCKOUT_CONV_OK
    && CONFIG_DONE && REGULATOR_ENABLE_IN;
  // Helper counters for the timed relations below.
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      ok_q <= 32'h0;
      stab_q <= 32'h0;
      last_q <= 8'h00;
    end
    else
    begin
      ok_q <= all_ok ? ok_q + 32'h1 : 32'h0;
      stab_q <= (VOLTAGE_IDENT_CODE != last_q) ? 32'h0 : stab_q + 32'h1;
      last_q <= VOLTAGE_IDENT_CODE;
    end
  end
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);
  // Converter released and ready low.
  sequence s_off;
    !REGULATOR_POWER_GOOD_OUT && OUTPUT_HIZ;
  endsequence
  AST_EN_OFF: assert property (!REGULATOR_ENABLE_IN && !LATCHED_OFF |=> s_off)
    else $error("enable low but output still driven");
  AST_UNDERVOLTAGE_LOCKOUT: assert property (!(UNDERVOLTAGE_LOCKOUT_VCC_OK && UNDERVOLTAGE_LOCKOUT_CONV_OK)
    && !LATCHED_OFF |=> s_off)
    else $error("supply low but output still driven");
  AST_BOOT: assert property (!REGULATOR_POWER_GOOD_OUT && !LATCHED_OFF
    |-> REF_CODE == 8'h4a && !LOADLINE_EN)
    else $error("boot level wrong before ready");
  AST_RUN: assert property (REGULATOR_POWER_GOOD_OUT
    |-> LOADLINE_EN && !OUTPUT_HIZ && !SOFT_START_ACTIVE && !LATCHED_OFF)
    else $error("ready outside run");
  AST_PG_RISE: assert property ($rose(REGULATOR_POWER_GOOD_OUT)
    |-> $past(SOFT_START_ACTIVE) && $past(all_ok))
    else $error("ready rose without target ramp");
  AST_TD1: assert property ($fell(OUTPUT_HIZ) |-> ok_q >= TD1_CYC)
    else $error("ramp began before start delay");
  AST_SETTLE: assert property (REGULATOR_POWER_GOOD_OUT && $changed(REF_CODE)
    |-> stab_q >= SETTLE_CYC - 2)
    else $error("code taken before settling");
  AST_OFF_ONLY: assert property ($rose(LATCHED_OFF)
    |-> $past(VOLTAGE_IDENT_CODE) == 8'h00 && !REGULATOR_POWER_GOOD_OUT)
    else $error("latched off without zero code");
  AST_LATCH: assert property (LATCHED_OFF |=> LATCHED_OFF && !REGULATOR_POWER_GOOD_OUT)
    else $error("latched off state left");
endmodule : rss_seq_chk
`default_nettype wire
